// [src/dem_input_mapper.sv]
// How it works
// - Eight inputs, each individually configured.
// - Per-input polarity picks triggering transition.
// - Rising means off-to-on; falling means on-to-off.
// - Level functions on while powered/unpowered per polarity.
// - Profile functions pulse once; outputs held.
// - Start launches loaded profile at step one.
// - Pause puts running profile into hold.
// - Resume returns held profile to run.
// - Terminate stops profile only when active.
// - Wait trigger releases a waiting step.
// - Trigger before waiting state is ignored.
// - Step next needs hold before input on.
// - Step previous needs hold before input on.
// - Chamber-off forces chamber outputs off while on.
// - All-off forces chamber and event outputs off.
// - Event-off forces customer event outputs off.
// - Switch mode drives digital output with input.
// - Shared functions simply merge; no arbitration.
// - Settings apply on accept; reselect discards edits.
// - Follower output stays off unless switch mode.
//
// The register offsets and the strobed register port were decided locally.
module dem_input_mapper
   import dem_pkg::*;
(
   input  wire logic              clk_sys_in,
   input  wire logic              arst_n_in,
   input  wire logic [NUM_IN-1:0] din_in,
   input  wire logic              prof_running_in,
   input  wire logic              prof_hold_in,
   input  wire logic              prof_waiting_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wr_data_in,
   input  wire logic              wr_en_in,
   input  wire logic              rd_en_in,
   output logic [DATA_W-1:0]      rd_data_out,
   output logic                   profile_start_out,
   output logic                   profile_pause_out,
   output logic                   profile_resume_out,
   output logic                   profile_terminate_out,
   output logic [NUM_IN-1:0]      wait_release_out,
   output logic                   step_next_out,
   output logic                   step_prev_out,
   output logic                   chamber_off_out,
   output logic                   event_off_out,
   output logic [NUM_IN-1:0]      switch_on_out
);

   logic [NUM_IN-1:0] sync1_q;
   logic [NUM_IN-1:0] sync2_q;
   logic [NUM_IN-1:0] sync3_q;
   logic [NUM_IN-1:0] lvl_q;
   logic [NUM_IN-1:0] lvl_d;
   logic [NUM_IN-1:0] prev_q;
   logic              hold_q;

   logic              cfg_pol_q [NUM_IN];
   dem_fn_t           cfg_fn_q  [NUM_IN];
   logic [SEL_W-1:0]  sel_q;
   logic              stage_pol_q;
   dem_fn_t           stage_fn_q;

   logic [NUM_IN-1:0] trig;
   logic [NUM_IN-1:0] on_st;
   logic [15:0]       fire;
   logic [15:0]       held;
   logic [NUM_IN-1:0] wait_hit;
   logic [NUM_IN-1:0] switch_hit;

   logic              wr_sel;
   logic              wr_edit;
   logic              wr_accept;
   logic [SEL_W-1:0]  wr_sel_val;

   assign wr_sel     = wr_en_in && (addr_in == OFF_SELECT);
   assign wr_edit    = wr_en_in && (addr_in == OFF_EDIT);
   assign wr_accept  = wr_en_in && (addr_in == OFF_ACCEPT) && wr_data_in[ACCEPT_BIT];
   assign wr_sel_val = wr_data_in[SEL_W-1:0];

   // Three-stage synchroniser; a level counts once stages two and three agree
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_q <= RST_VEC;
         sync2_q <= RST_VEC;
         sync3_q <= RST_VEC;
      end else begin
         sync1_q <= din_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign lvl_d = (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & lvl_q);

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lvl_q  <= RST_VEC;
         prev_q <= RST_VEC;
         hold_q <= 1'b0;
      end else begin
         lvl_q  <= lvl_d;
         prev_q <= lvl_q;
         hold_q <= prof_hold_in;
      end
   end

   // Per-input trigger and on state, merged per function code
   always_comb begin
      fire = 16'h0000;
      held = 16'h0000;
      for (int i = 0; i < NUM_IN; i++) begin
         if (cfg_pol_q[i] == POL_RISING) begin
            trig[i]  = lvl_q[i] & ~prev_q[i];
            on_st[i] = lvl_q[i];
         end else begin
            trig[i]  = ~lvl_q[i] & prev_q[i];
            on_st[i] = ~lvl_q[i];
         end
         // Several inputs on one function simply OR together
         fire[cfg_fn_q[i]] = fire[cfg_fn_q[i]] | trig[i];
         held[cfg_fn_q[i]] = held[cfg_fn_q[i]] | on_st[i];
         wait_hit[i]   = trig[i] && (cfg_fn_q[i] == FN_WAIT_TRIG)
                         && prof_waiting_in;
         switch_hit[i] = on_st[i] && (cfg_fn_q[i] == FN_SWITCH);
      end
   end

   // Profile commands: one pulse per detected transition
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         profile_start_out     <= 1'b0;
         profile_pause_out     <= 1'b0;
         profile_resume_out    <= 1'b0;
         profile_terminate_out <= 1'b0;
         wait_release_out      <= RST_VEC;
         step_next_out         <= 1'b0;
         step_prev_out         <= 1'b0;
      end else begin
         profile_start_out     <= fire[FN_START];
         profile_pause_out     <= fire[FN_PAUSE] && prof_running_in;
         profile_resume_out    <= fire[FN_RESUME] && prof_hold_in;
         profile_terminate_out <= fire[FN_TERMINATE]
                                  && (prof_running_in || prof_hold_in);
         wait_release_out      <= wait_hit;
         // Hold must predate the edge, so a pause on the same edge does not step
         step_next_out         <= fire[FN_STEP_NEXT] && hold_q;
         step_prev_out         <= fire[FN_STEP_PREV] && hold_q;
      end
   end

   // Output overrides follow the on state for as long as it lasts
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         chamber_off_out <= 1'b0;
         event_off_out   <= 1'b0;
         switch_on_out   <= RST_VEC;
      end else begin
         chamber_off_out <= held[FN_CHAMBER_OFF] | held[FN_ALL_OFF];
         event_off_out   <= held[FN_EVENT_OFF] | held[FN_ALL_OFF];
         switch_on_out   <= switch_hit;
      end
   end

   // Staged edit of the selected input; reselecting reloads and drops edits
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_q       <= RST_SEL;
         stage_pol_q <= RST_POL;
         stage_fn_q  <= RST_FN;
      end else if (wr_sel) begin
         sel_q       <= wr_sel_val;
         stage_pol_q <= cfg_pol_q[wr_sel_val];
         stage_fn_q  <= cfg_fn_q[wr_sel_val];
      end else if (wr_edit) begin
         stage_pol_q <= wr_data_in[EDIT_POL_BIT];
         stage_fn_q  <= wr_data_in[EDIT_FN_LSB +: FN_W];
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < NUM_IN; i++) begin
            cfg_pol_q[i] <= RST_POL;
            cfg_fn_q[i]  <= RST_FN;
         end
      end else if (wr_accept) begin
         cfg_pol_q[sel_q] <= stage_pol_q;
         cfg_fn_q[sel_q]  <= stage_fn_q;
      end
   end

   // Read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= RST_WORD;
      end else begin
         rd_data_out <= RST_WORD;
         if (rd_en_in) begin
            unique case (addr_in)
               OFF_SELECT: rd_data_out[SEL_W-1:0] <= sel_q;
               OFF_EDIT: begin
                  rd_data_out[EDIT_POL_BIT]         <= stage_pol_q;
                  rd_data_out[EDIT_FN_LSB +: FN_W]  <= stage_fn_q;
               end
               OFF_STATUS: begin
                  rd_data_out[STAT_LVL_LSB +: NUM_IN] <= lvl_q;
                  rd_data_out[STAT_ON_LSB +: NUM_IN]  <= on_st;
               end
               OFF_ACTIVE: begin
                  rd_data_out[ACT_CHAMB_BIT]             <= chamber_off_out;
                  rd_data_out[ACT_EVENT_BIT]             <= event_off_out;
                  rd_data_out[ACT_SWITCH_LSB +: NUM_IN]  <= switch_on_out;
               end
               default: rd_data_out <= RST_WORD;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   property p_sync_agree;
      (lvl_q != $past(lvl_q)) |->
         ((lvl_q ^ $past(lvl_q)) & ($past(sync2_q) ^ $past(sync3_q))) == RST_VEC;
   endproperty
   a_sync_agree: assert property (p_sync_agree)
      else $error("level changed while sync stages disagreed");

   property p_rise_start;
      ($rose(lvl_q[0]) && cfg_pol_q[0] == POL_RISING && cfg_fn_q[0] == FN_START)
         |=> profile_start_out;
   endproperty
   a_rise_start: assert property (p_rise_start)
      else $error("rising edge on input 0 did not start profile");

   property p_fall_start;
      ($fell(lvl_q[0]) && cfg_pol_q[0] == POL_FALLING && cfg_fn_q[0] == FN_START)
         |=> profile_start_out;
   endproperty
   a_fall_start: assert property (p_fall_start)
      else $error("falling edge on input 0 did not start profile");

   property p_pause;
      profile_pause_out |-> $past(prof_running_in) && $past(fire[FN_PAUSE]);
   endproperty
   a_pause: assert property (p_pause)
      else $error("pause issued without running profile");

   property p_resume;
      profile_resume_out |-> $past(prof_hold_in);
   endproperty
   a_resume: assert property (p_resume)
      else $error("resume issued without held profile");

   property p_terminate;
      profile_terminate_out |-> $past(prof_running_in || prof_hold_in);
   endproperty
   a_terminate: assert property (p_terminate)
      else $error("terminate issued with no active profile");

   property p_wait;
      (wait_release_out != RST_VEC) |-> $past(prof_waiting_in);
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait release outside waiting state");

   property p_step_next;
      step_next_out |-> $past(prof_hold_in, 2);
   endproperty
   a_step_next: assert property (p_step_next)
      else $error("step next without prior hold");

   property p_step_prev;
      step_prev_out |-> $past(prof_hold_in, 2);
   endproperty
   a_step_prev: assert property (p_step_prev)
      else $error("step previous without prior hold");

   property p_chamber;
      chamber_off_out == $past(held[FN_CHAMBER_OFF] | held[FN_ALL_OFF]);
   endproperty
   a_chamber: assert property (p_chamber)
      else $error("chamber override does not follow input");

   property p_switch;
      switch_on_out[NUM_IN-1] |-> $past(on_st[NUM_IN-1])
         && $past(cfg_fn_q[NUM_IN-1] == FN_SWITCH);
   endproperty
   a_switch: assert property (p_switch)
      else $error("follower output on without switch mode");

   property p_reselect;
      wr_sel |=> (stage_fn_q == cfg_fn_q[sel_q]) && (stage_pol_q == cfg_pol_q[sel_q]);
   endproperty
   a_reselect: assert property (p_reselect)
      else $error("reselect did not discard staged edits");

   property p_all_off;
      $past(held[FN_ALL_OFF]) |-> chamber_off_out && event_off_out;
   endproperty
   a_all_off: assert property (p_all_off)
      else $error("all-off input did not force both overrides");

   property p_event_off;
      event_off_out == $past(held[FN_EVENT_OFF] | held[FN_ALL_OFF]);
   endproperty
   a_event_off: assert property (p_event_off)
      else $error("event override does not follow input");

   // On state is the filtered level seen through the polarity, checked on the last input
   property p_on_state;
      on_st[NUM_IN-1] == (lvl_q[NUM_IN-1] ^ (cfg_pol_q[NUM_IN-1] == POL_FALLING));
   endproperty
   a_on_state: assert property (p_on_state)
      else $error("on state disagrees with polarity");

   property p_switch_off;
      !$past(on_st[NUM_IN-1]) |-> !switch_on_out[NUM_IN-1];
   endproperty
   a_switch_off: assert property (p_switch_off)
      else $error("follower output on while input off");

   property p_accept;
      wr_accept |=> (cfg_fn_q[sel_q] == $past(stage_fn_q))
                    && (cfg_pol_q[sel_q] == $past(stage_pol_q));
   endproperty
   a_accept: assert property (p_accept)
      else $error("accept did not commit staged settings");

   property p_rd_idle;
      !$past(rd_en_in) |-> (rd_data_out == RST_WORD);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data present without a read strobe");

   c_start:   cover property (profile_start_out);
   c_step:    cover property (step_next_out);
   c_alloff:  cover property (chamber_off_out && event_off_out);
   c_switch:  cover property (switch_on_out != RST_VEC);
   c_wait:    cover property (wait_release_out != RST_VEC);

endmodule // dem_input_mapper

// [include/dem_pkg.sv]
package dem_pkg;

   localparam int NUM_IN = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SEL_W  = 3;
   localparam int FN_W   = 4;

   typedef logic [FN_W-1:0] dem_fn_t;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_SELECT = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_EDIT   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_ACCEPT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h10;

   // Field positions
   localparam int EDIT_POL_BIT   = 0;
   localparam int EDIT_FN_LSB    = 4;
   localparam int ACCEPT_BIT     = 0;
   localparam int STAT_LVL_LSB   = 0;
   localparam int STAT_ON_LSB    = 8;
   localparam int ACT_CHAMB_BIT  = 0;
   localparam int ACT_EVENT_BIT  = 1;
   localparam int ACT_SWITCH_LSB = 8;

   // Transition polarity
   localparam logic POL_RISING  = 1'b0;
   localparam logic POL_FALLING = 1'b1;

   // Input functions; codes above FN_SWITCH do nothing
   localparam dem_fn_t FN_NONE        = 4'h0;
   localparam dem_fn_t FN_START       = 4'h1;
   localparam dem_fn_t FN_PAUSE       = 4'h2;
   localparam dem_fn_t FN_RESUME      = 4'h3;
   localparam dem_fn_t FN_TERMINATE   = 4'h4;
   localparam dem_fn_t FN_WAIT_TRIG   = 4'h5;
   localparam dem_fn_t FN_STEP_NEXT   = 4'h6;
   localparam dem_fn_t FN_STEP_PREV   = 4'h7;
   localparam dem_fn_t FN_CHAMBER_OFF = 4'h8;
   localparam dem_fn_t FN_ALL_OFF     = 4'h9;
   localparam dem_fn_t FN_EVENT_OFF   = 4'hA;
   localparam dem_fn_t FN_SWITCH      = 4'hB;

   // Reset values
   localparam logic               RST_POL  = POL_RISING;
   localparam dem_fn_t            RST_FN   = FN_NONE;
   localparam logic [SEL_W-1:0]   RST_SEL  = 3'h0;
   localparam logic [NUM_IN-1:0]  RST_VEC  = 8'h00;
   localparam logic [DATA_W-1:0]  RST_WORD = 32'h0000_0000;

endpackage : dem_pkg

// [bench/dem_switch_model.sv]
// Field contacts feeding the input pins; bounce_in flips a pin for as long as it is held
module dem_switch_model
   import dem_pkg::*;
(
   input  wire logic              clk_sys_in,
   input  wire logic              arst_n_in,
   input  wire logic [NUM_IN-1:0] contact_in,
   input  wire logic [NUM_IN-1:0] bounce_in,
   output logic [NUM_IN-1:0]      din_out
);
   timeunit 1ns;
   timeprecision 1ps;

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         din_out <= RST_VEC;
      end else begin
         din_out <= contact_in ^ bounce_in;
      end
   end
endmodule // dem_switch_model

// [bench/testbench.sv]
module testbench
   import dem_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys_in = 1'b0, arst_n_in = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic run_s = 1'b0, hold_s = 1'b0, wait_s = 1'b0;
   logic [NUM_IN-1:0] contact = 8'h00, bounce = 8'h00, din, wait_rel, sw_on;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0, rdata, d;
   logic st, pa, re, te, sn, sp, ch_off, ev_off;
   int n_fail = 0, samples_checked = 0, cycles = 0;

   dem_switch_model sw_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .contact_in(contact),
      .bounce_in(bounce), .din_out(din));
   dem_input_mapper dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .din_in(din),
      .prof_running_in(run_s), .prof_hold_in(hold_s), .prof_waiting_in(wait_s),
      .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .rd_data_out(rdata), .profile_start_out(st), .profile_pause_out(pa),
      .profile_resume_out(re), .profile_terminate_out(te), .wait_release_out(wait_rel),
      .step_next_out(sn), .step_prev_out(sp), .chamber_off_out(ch_off),
      .event_off_out(ev_off), .switch_on_out(sw_on));

   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // Ceiling well above the roughly 740 cycles the sequence needs
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys_in);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk_sys_in);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys_in);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk_sys_in);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic cfg(input int i, input logic pol, input dem_fn_t fn);
      wr(OFF_SELECT, 32'(i));
      wr(OFF_EDIT, (32'(fn) << EDIT_FN_LSB) | 32'(pol));
      wr(OFF_ACCEPT, 32'h1);
   endtask

   task automatic pin(input int i, input logic v);
      @(posedge clk_sys_in);
      contact[i] <= v;
   endtask

   function automatic logic cmd_bit(dem_fn_t fn, int i);
      case (fn)
         FN_START: return st;
         FN_PAUSE: return pa;
         FN_RESUME: return re;
         FN_TERMINATE: return te;
         FN_WAIT_TRIG: return wait_rel[i];
         FN_STEP_NEXT: return sn;
         FN_STEP_PREV: return sp;
         default: return 1'b0;
      endcase
   endfunction

   task automatic count_cmd(input dem_fn_t fn, input int i, output int n);
      n = 0;
      repeat (10) begin
         @(posedge clk_sys_in);
         #1 if (cmd_bit(fn, i) === 1'b1) n++;
      end
   endtask

   // Flags are {running, hold, waiting}, raised before the pin moves
   task automatic run_cmd(input int i, input logic pol, input dem_fn_t fn,
                          input logic [2:0] fl, input int exp);
      int n;
      pin(i, pol);
      repeat (8) @(posedge clk_sys_in);
      cfg(i, pol, fn);
      @(posedge clk_sys_in);
      {run_s, hold_s, wait_s} <= fl;
      pin(i, ~pol);
      count_cmd(fn, i, n);
      chk(32'(n), 32'(exp), "pulses on trigger");
      pin(i, pol);
      count_cmd(fn, i, n);
      chk(32'(n), 32'h0, "pulses on release");
      @(posedge clk_sys_in);
      {run_s, hold_s, wait_s} <= 3'h0;
   endtask

   task automatic lvl(input logic pol, input dem_fn_t fn, input logic [31:0] exp);
      pin(7, pol);
      cfg(7, pol, fn);
      repeat (8) @(posedge clk_sys_in);
      rd(OFF_ACTIVE, d);
      chk(d, 32'h0, "active while input off");
      pin(7, ~pol);
      repeat (8) @(posedge clk_sys_in);
      #1 chk({16'h0, sw_on, 6'h0, ev_off, ch_off}, exp, "level outputs");
      rd(OFF_ACTIVE, d);
      chk(d, exp, "active register");
      rd(OFF_STATUS, d);
      chk(32'({d[15], d[7]}), 32'({1'b1, ~pol}), "status bits");
      pin(7, pol);
      repeat (8) @(posedge clk_sys_in);
      #1 chk({16'h0, sw_on, 6'h0, ev_off, ch_off}, 32'h0, "released");
   endtask

   task automatic t_reset();
      rd(OFF_SELECT, d);
      chk(d, 32'h0, "select reset");
      rd(OFF_EDIT, d);
      chk(d, 32'h0, "edit reset");
      rd(OFF_ACTIVE, d);
      chk(d, 32'h0, "active reset");
      rd(8'h40, d);
      chk(d, 32'h0, "unmapped read");
   endtask

   task automatic t_cmds();
      logic [2:0] fl [1:7] = '{3'b000, 3'b100, 3'b010, 3'b100, 3'b001, 3'b010, 3'b010};
      for (int f = 1; f <= 7; f++) begin
         run_cmd(f - 1, f[0], dem_fn_t'(f), fl[f], 1);
      end
      run_cmd(1, POL_RISING, FN_PAUSE, 3'b010, 0);
      run_cmd(3, POL_RISING, FN_TERMINATE, 3'b000, 0);
      run_cmd(4, POL_RISING, FN_WAIT_TRIG, 3'b100, 0);
      run_cmd(5, POL_RISING, FN_STEP_NEXT, 3'b100, 0);
      run_cmd(0, POL_RISING, FN_START, 3'b000, 1);
   endtask

   task automatic t_levels();
      lvl(POL_FALLING, FN_CHAMBER_OFF, 32'h1);
      lvl(POL_FALLING, FN_ALL_OFF, 32'h3);
      lvl(POL_RISING, FN_EVENT_OFF, 32'h2);
      lvl(POL_FALLING, FN_SWITCH, 32'h8000);
      lvl(POL_RISING, FN_SWITCH, 32'h8000);
      lvl(POL_RISING, FN_NONE, 32'h0);
   endtask

   task automatic t_glitch_discard();
      int n;
      @(posedge clk_sys_in);
      bounce[0] <= 1'b1;
      @(posedge clk_sys_in);
      bounce[0] <= 1'b0;
      count_cmd(FN_START, 0, n);
      chk(32'(n), 32'h0, "glitch fired");
      wr(OFF_SELECT, 32'h5);
      wr(OFF_EDIT, 32'h10);
      wr(OFF_ACCEPT, 32'h2);
      wr(OFF_SELECT, 32'h4);
      wr(OFF_SELECT, 32'h5);
      rd(OFF_EDIT, d);
      chk(d, 32'h60, "edit not discarded");
      rd(OFF_ACCEPT, d);
      chk(d, 32'h0, "accept reads zero");
   endtask

   initial begin
      repeat (6) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_cmds();
      t_levels();
      t_glitch_discard();
      test_done();
   end
endmodule // testbench
